// ==== hw/halt_consts.svh ====
// constants and notes for the halt power controller
// Notes on behaviour
// - halt instruction enters halt, cpu powered down
// - oscillator and system clock keep running in halt
// - halted cpu stopped, program counter frozen
// - watchdog oscillator runs, counter runs if enabled
// - enabled peripherals keep operating during halt
// - any interrupt request ends halt
// - watchdog timeout ends halt, interrupt or reset
// - power-on, brownout, external reset also end halt
// - per-peripheral disable gates clock or cuts power
`ifndef HALT_CONSTS_SVH
`define HALT_CONSTS_SVH
`define HALT_NUM_PERIPH    8
`define HALT_PDIS_RESET    8'h00
`define HALT_RST_HOLD_CYC  4'h4
`define HALT_ACT_BIT       0
`define HALT_HLT_BIT       1
`define HALT_RST_BIT       2
`endif

// ==== hw/halt_pkg.sv ====
// types for the halt power controller
package halt_pkg;
    // one-hot controller states
    typedef enum logic [2:0] {
        ST_RUN   = 3'b001,
        ST_HALT  = 3'b010,
        ST_RESET = 3'b100
    } halt_state_t;
    // wake cause reported to the core
    typedef struct packed {
        logic by_irq;
        logic by_wdt;
        logic by_reset;
    } wake_cause_t;
    // reset source inputs grouped
    typedef struct packed {
        logic por;
        logic bor;
        logic ext;
    } reset_src_t;
endpackage

// ==== hw/periph_gate.sv ====
// per-peripheral clock gate enable and power switch control
`timescale 1ns/1ps
`default_nettype none
module periph_gate #(
    parameter int N = 8
) (
    // clock and reset
    input  wire logic         clk,
    input  wire logic         rst_b,
    // control
    input  wire logic [N-1:0] disable_bits,
    input  wire logic [N-1:0] pwr_mode,
    // results
    output logic      [N-1:0] clk_en,
    output logic      [N-1:0] pwr_en
);
    logic [N-1:0] clk_en_r;   // registered clock enables
    logic [N-1:0] pwr_en_r;   // registered power enables
    logic [N-1:0] clk_en_nxt;
    logic [N-1:0] pwr_en_nxt;

    // halt plays no part here: disable is independent of low-power mode
    genvar g;
    generate
        for (g = 0; g < N; g++) begin : g_per
            // power-mode peripherals lose power, others lose clock
            always_comb begin
                clk_en_nxt[g] = ~disable_bits[g] | pwr_mode[g];
                pwr_en_nxt[g] = ~(disable_bits[g] & pwr_mode[g]);
            end
        end
    endgenerate

    // register so gate enables never glitch
    always_ff @(posedge clk) begin
        if (!rst_b) begin
            clk_en_r <= '1;
            pwr_en_r <= '1;
        end else begin
            clk_en_r <= clk_en_nxt;
            pwr_en_r <= pwr_en_nxt;
        end
    end
    assign clk_en = clk_en_r;
    assign pwr_en = pwr_en_r;
endmodule
`default_nettype wire

// ==== hw/halt_ctrl.sv ====
// halt mode controller with wake sources and peripheral disables
`timescale 1ns/1ps
`default_nettype none
`include "halt_consts.svh"
module halt_ctrl #(
    parameter int NP = `HALT_NUM_PERIPH
) (
    // clock and reset
    input  wire logic                 clk,
    input  wire logic                 rst_b,
    // cpu side, same clock
    input  wire logic                 halt_instr,
    input  wire logic                 irq_pending,
    // watchdog, from its own rc domain
    input  wire logic                 wdt_enable,
    input  wire logic                 wdt_timeout,
    // reset sources, asynchronous pins
    input  wire halt_pkg::reset_src_t reset_src,
    // peripheral disable controls
    input  wire logic [NP-1:0]        periph_disable,
    input  wire logic [NP-1:0]        periph_pwr_mode,
    // core control
    output logic                      cpu_run,
    output logic                      pc_advance_en,
    output logic                      cpu_reset_req,
    output logic                      irq_service,
    output logic                      halted,
    output halt_pkg::wake_cause_t     wake_cause,
    // clocks and watchdog
    output logic                      osc_en,
    output logic                      sysclk_en,
    output logic                      wdt_osc_en,
    output logic                      wdt_count_en,
    // peripherals
    output logic [NP-1:0]             periph_clk_en,
    output logic [NP-1:0]             periph_pwr_en
);
    // the cpu side arrives on this clock and is read directly; the watchdog
    // and the reset pins come from other domains and are synchronised first
    // nothing here needs a clock enable; every flop runs on every edge
    // two-stage synchronisers for async inputs
    // each pin gets its own pair; the pins need not be coherent
    logic [1:0] wdt_s1_r;      // first stage, read only by second
    logic [1:0] wdt_s2_r;      // {enable, timeout} synced
    logic [2:0] rst_s1_r;      // first stage of reset sources
    logic [2:0] rst_s2_r;      // synced reset sources
    logic [1:0] wdt_s1_nxt;
    logic [2:0] rst_s1_nxt;

    // the watchdog runs from its own rc oscillator, so both its lines are
    // asynchronous levels; a pulse shorter than one clock may be missed
    // synchroniser next values
    always_comb begin
        wdt_s1_nxt = {wdt_enable, wdt_timeout};
        rst_s1_nxt = {reset_src.por, reset_src.bor, reset_src.ext};
    end

    // synchroniser flops
    // the first stage may go metastable; only the second stage is read
    // all stages clear in reset, so no false event follows it
    always_ff @(posedge clk) begin
        if (!rst_b) begin
            wdt_s1_r <= 2'h0;
            wdt_s2_r <= 2'h0;
            rst_s1_r <= 3'h0;
            rst_s2_r <= 3'h0;
        end else begin
            wdt_s1_r <= wdt_s1_nxt;
            wdt_s2_r <= wdt_s1_r;
            rst_s1_r <= rst_s1_nxt;
            rst_s2_r <= rst_s1_r;
        end
    end

    // decoded views of the synchronised inputs
    logic wdt_en_sync;   // watchdog enabled, synced
    logic wdt_to_sync;   // watchdog timeout, synced
    logic any_reset;     // any reset source active
    assign wdt_en_sync = wdt_s2_r[1];
    assign wdt_to_sync = wdt_s2_r[0];
    // the three reset sources are not told apart; any one is enough
    assign any_reset   = |rst_s2_r;

    // state, wake cause and reset hold counter
    // one-hot code; each decode below still compares all three state bits
    halt_pkg::halt_state_t state_r;
    halt_pkg::halt_state_t state_nxt;
    halt_pkg::wake_cause_t cause_r;
    halt_pkg::wake_cause_t cause_nxt;
    logic [3:0]            hold_r;     // cycles left of reset pulse
    logic [3:0]            hold_nxt;
    logic                  svc_r;      // one-cycle interrupt service pulse
    logic                  svc_nxt;

    // next-state logic; reset sources take priority over interrupts
    // defaults hold the state; the service pulse lasts a single cycle
    always_comb begin
        state_nxt = state_r;
        cause_nxt = cause_r;
        hold_nxt  = hold_r;
        svc_nxt   = 1'b0;
        case (state_r)
            halt_pkg::ST_RUN: begin
                // a reset source wins over a halt instruction in the same cycle
                if (any_reset) begin
                    // reset from run keeps the last wake cause
                    state_nxt = halt_pkg::ST_RESET;
                    hold_nxt  = `HALT_RST_HOLD_CYC;
                end else if (halt_instr) begin
                    // halt is honoured only here; the core stops at this edge
                    state_nxt = halt_pkg::ST_HALT;
                end
            end
            halt_pkg::ST_HALT: begin
                // wake sources by priority: reset, then watchdog, then interrupt
                if (any_reset) begin
                    // reset wake: run the full reset sequence
                    state_nxt = halt_pkg::ST_RESET;
                    hold_nxt  = `HALT_RST_HOLD_CYC;
                    cause_nxt = '{by_irq: 1'b0, by_wdt: 1'b0, by_reset: 1'b1};
                end else if (wdt_to_sync) begin
                    // either watchdog flavour ends halt; the watchdog itself
                    // raises its irq or reset afterwards
                    state_nxt = halt_pkg::ST_RUN;
                    cause_nxt = '{by_irq: 1'b0, by_wdt: 1'b1, by_reset: 1'b0};
                end else if (irq_pending) begin
                    // the core services the pending request before anything else
                    state_nxt = halt_pkg::ST_RUN;
                    svc_nxt   = 1'b1;
                    cause_nxt = '{by_irq: 1'b1, by_wdt: 1'b0, by_reset: 1'b0};
                end
            end
            halt_pkg::ST_RESET: begin
                // hold reset while any source stays active
                // the count reloads on every active cycle, so a bouncing pin keeps
                // the core in reset until the pin has been quiet for the hold time
                if (any_reset) begin
                    hold_nxt = `HALT_RST_HOLD_CYC;
                end else if (hold_r != 4'h0) begin
                    // count down the hold time
                    hold_nxt = hold_r - 4'h1;
                end else begin
                    // hold spent: release the core into its reset sequence
                    state_nxt = halt_pkg::ST_RUN;
                end
            end
            default: begin
                // illegal code, recover to run
                state_nxt = halt_pkg::ST_RUN;
            end
        endcase
    end

    // state registers
    // the wake cause survives until the next wake from halt
    always_ff @(posedge clk) begin
        if (!rst_b) begin
            state_r <= halt_pkg::ST_RUN;
            cause_r <= '0;
            hold_r  <= 4'h0;
            svc_r   <= 1'b0;
        end else begin
            state_r <= state_nxt;
            cause_r <= cause_nxt;
            hold_r  <= hold_nxt;
            svc_r   <= svc_nxt;
        end
    end

    // cpu_run follows the next state, so it drops at the same edge as halted
    // rises and the program counter takes no further step
    // output register next values
    logic run_nxt;
    logic wdtc_nxt;
    logic run_r;
    logic wdtc_r;
    always_comb begin
        run_nxt  = (state_nxt == halt_pkg::ST_RUN);
        wdtc_nxt = wdt_en_sync;
    end

    // output registers
    // reset leaves the core running with the watchdog counter stopped
    always_ff @(posedge clk) begin
        if (!rst_b) begin
            run_r  <= 1'b1;
            wdtc_r <= 1'b0;
        end else begin
            run_r  <= run_nxt;
            wdtc_r <= wdtc_nxt;
        end
    end

    // core control outputs
    // halted and reset request are plain decodes of the one-hot state
    assign cpu_run       = run_r;
    assign pc_advance_en = run_r;
    assign halted        = (state_r == halt_pkg::ST_HALT);
    assign cpu_reset_req = (state_r == halt_pkg::ST_RESET);
    assign irq_service   = svc_r;
    assign wake_cause    = cause_r;

    // clocks stay on in halt; only stop mode, not built here, turns them off
    // keeping them on is what lets enabled peripherals run through halt
    assign osc_en       = 1'b1;
    assign sysclk_en    = 1'b1;
    assign wdt_osc_en   = 1'b1;
    assign wdt_count_en = wdtc_r;

    // peripherals: only their own disable and power-mode bits matter, halt does not
    // the gate registers its enables, one cycle behind the disable inputs
    periph_gate #(
        .N(NP)
    ) u_gate (
        .clk          (clk),
        .rst_b        (rst_b),
        .disable_bits (periph_disable),
        .pwr_mode     (periph_pwr_mode),
        .clk_en       (periph_clk_en),
        .pwr_en       (periph_pwr_en)
    );
endmodule
`default_nettype wire

// ==== tb/halt_monitor.sv ====
// assertion checker for the halt controller ports
`timescale 1ns/1ps
`default_nettype none
module halt_monitor #(
    parameter int NP = 8
) (
    // clock, reset and core inputs
    input wire logic                 clk,
    input wire logic                 rst_b,
    input wire logic                 halt_instr,
    input wire logic                 irq_pending,
    input wire logic                 wdt_enable,
    input wire logic                 wdt_timeout,
    input wire halt_pkg::reset_src_t reset_src,
    // peripheral controls
    input wire logic [NP-1:0]        periph_disable,
    input wire logic [NP-1:0]        periph_pwr_mode,
    // watched outputs
    input wire logic                 cpu_run,
    input wire logic                 pc_advance_en,
    input wire logic                 cpu_reset_req,
    input wire logic                 irq_service,
    input wire logic                 halted,
    input wire halt_pkg::wake_cause_t wake_cause,
    input wire logic                 osc_en,
    input wire logic                 sysclk_en,
    input wire logic                 wdt_osc_en,
    input wire logic                 wdt_count_en,
    input wire logic [NP-1:0]        periph_clk_en,
    input wire logic [NP-1:0]        periph_pwr_en
);
    default clocking cb @(posedge clk); endclocking
    default disable iff (!rst_b);
    // halt entry: flag up and the core stopped at the same edge
    sequence halt_entry;
        halted && !cpu_run && !pc_advance_en && !cpu_reset_req;
    endsequence
    // interrupt wake: one service pulse with the core running, then no pulse
    sequence irq_wake;
        (!halted && irq_service && wake_cause.by_irq && cpu_run) ##1 !irq_service;
    endsequence
    // watchdog wake: still halted on the acting edge, then running, no pulse
    sequence wdt_wake;
        halted ##1 (!halted && wake_cause.by_wdt && !irq_service && cpu_run);
    endsequence
    // the synchronisers show a pin two edges late, hence the depth-two lookbacks
    AST_HALT_ENTRY: assert property (
        halt_instr && cpu_run && !halted && !cpu_reset_req && !$past(|reset_src, 2)
        |=> halt_entry)
        else $error("halt entry wrong");
    AST_CLOCKS_ON: assert property (osc_en && sysclk_en && wdt_osc_en)
        else $error("clock enable dropped");
    AST_CORE_FROZEN: assert property (halted |-> !cpu_run && !pc_advance_en)
        else $error("core runs in halt");
    AST_WDT_COUNT: assert property ($rose(wdt_enable) |-> ##3 wdt_count_en)
        else $error("watchdog count not enabled");
    AST_WDT_STOP: assert property ($fell(wdt_enable) |-> ##3 !wdt_count_en)
        else $error("watchdog count not stopped");
    AST_PERIPH_CLK: assert property (
        $past(rst_b) |-> periph_clk_en == ~($past(periph_disable) & ~$past(periph_pwr_mode)))
        else $error("clock gate wrong");
    AST_PERIPH_PWR: assert property (
        $past(rst_b) |-> periph_pwr_en == ~($past(periph_disable) & $past(periph_pwr_mode)))
        else $error("power switch wrong");
    AST_IRQ_WAKE: assert property (
        halted && irq_pending && !$past(wdt_timeout, 2) && !$past(|reset_src, 2)
        |=> irq_wake)
        else $error("interrupt wake wrong");
    AST_WDT_WAKE: assert property (
        halted && $rose(wdt_timeout) && !irq_pending && !(|reset_src)
            && !$past(|reset_src) && !$past(|reset_src, 2) && !$past(wdt_timeout, 2)
            ##1 !irq_pending
        |-> ##1 wdt_wake)
        else $error("watchdog wake wrong");
    AST_RESET_WAKE: assert property (
        $rose(|reset_src) |-> ##3 (cpu_reset_req && !cpu_run && !halted))
        else $error("reset source ignored");
    AST_RESET_SEQ: assert property (
        cpu_reset_req |-> !cpu_run && !pc_advance_en && !halted && !irq_service)
        else $error("reset wake serviced irq");
    AST_RESET_EXIT: assert property (
        $fell(cpu_reset_req) |-> cpu_run && !halted && !irq_service)
        else $error("reset exit wrong");
    AST_SVC_PULSE: assert property (irq_service |=> !irq_service)
        else $error("service pulse too long");
endmodule
bind halt_ctrl halt_monitor #(.NP(NP)) i_halt_monitor (.clk(clk), .rst_b(rst_b),
    .halt_instr(halt_instr), .irq_pending(irq_pending), .wdt_enable(wdt_enable),
    .wdt_timeout(wdt_timeout), .reset_src(reset_src), .periph_disable(periph_disable),
    .periph_pwr_mode(periph_pwr_mode), .cpu_run(cpu_run), .pc_advance_en(pc_advance_en),
    .cpu_reset_req(cpu_reset_req), .irq_service(irq_service), .halted(halted),
    .wake_cause(wake_cause), .osc_en(osc_en), .sysclk_en(sysclk_en), .wdt_osc_en(wdt_osc_en),
    .wdt_count_en(wdt_count_en), .periph_clk_en(periph_clk_en), .periph_pwr_en(periph_pwr_en));
`default_nettype wire

// ==== tb/test_halt_mode_power_control.sv ====
// self-checking bench for the halt controller
`timescale 1ns/1ps
`default_nettype none
`include "halt_consts.svh"
`define CHK(n, e, g) begin num_checks++; if ((g) !== (e)) begin errors++; \
    $display("mismatch %s exp %h got %h", n, e, g); end end
module test_halt_mode_power_control;
    logic clk = 1'b0;                        // system clock
    logic rst_b = 1'b0;                      // sync reset
    logic halt_instr = 1'b0;                 // halt pulse
    logic irq_pending = 1'b0;                // interrupt level
    logic wdt_enable = 1'b0;                 // watchdog on
    logic wdt_timeout = 1'b0;                // watchdog expiry
    halt_pkg::reset_src_t reset_src = '0;    // por bor ext
    logic [7:0] dis = 8'h00;                 // peripheral disables
    logic [7:0] mode = 8'h00;                // power cut instead of gate
    logic cpu_run, pc_en, rreq, isvc, halted, osc, sclk, wosc, wcnt;
    logic [7:0] pclk, ppwr;
    halt_pkg::wake_cause_t wc;
    int errors = 0, num_checks = 0, cyc = 0, n;
    logic [31:0] seed = 32'ha2f2c6b5;
    logic [31:0] rnd;
    logic [15:0] expq[$];                    // model: expected enables
    logic [15:0] exp16;
    halt_ctrl #(.NP(8)) i_halt_ctrl (.clk(clk), .rst_b(rst_b), .halt_instr(halt_instr),
        .irq_pending(irq_pending), .wdt_enable(wdt_enable), .wdt_timeout(wdt_timeout),
        .reset_src(reset_src), .periph_disable(dis), .periph_pwr_mode(mode),
        .cpu_run(cpu_run), .pc_advance_en(pc_en), .cpu_reset_req(rreq), .irq_service(isvc),
        .halted(halted), .wake_cause(wc), .osc_en(osc), .sysclk_en(sclk), .wdt_osc_en(wosc),
        .wdt_count_en(wcnt), .periph_clk_en(pclk), .periph_pwr_en(ppwr));
    // free-running clock, 8 ns
    initial forever #4 clk = ~clk;
    // hang guard: the whole run needs about a hundred cycles
    always @(posedge clk) begin
        cyc++;
        if (cyc == 3000) begin
            errors++;
            wrap_up();
        end
    end
    // inputs move on the falling edge only
    task automatic tick();
        @(negedge clk);
    endtask
    function automatic logic [31:0] xs();
        seed ^= seed << 13;
        seed ^= seed >> 17;
        seed ^= seed << 5;
        return seed;
    endfunction
    // one halt instruction from run
    task automatic go_halt();
        halt_instr = 1'b1;
        tick();
        halt_instr = 1'b0;
        `CHK("halted", 1'b1, halted)
        tick();
        `CHK("core stopped", 2'h0, {cpu_run, pc_en})
    endtask
    task automatic wrap_up();
        $display("checks %0d errors %0d", num_checks, errors);
        if (errors == 0 && num_checks > 0) $display("TB: PASS");
        else $display("TB: FAIL");
        $finish;
    endtask
    initial begin
        repeat (4) tick();
        rst_b = 1'b1;
        `CHK("reset state", 5'h10, {cpu_run, halted, wc})
        `CHK("reset outs", 20'h8ffff, {pc_en, rreq, isvc, wcnt, pclk, ppwr})
        go_halt();
        halt_instr = 1'b1;               // second halt while halted is ignored
        tick();
        halt_instr = 1'b0;
        `CHK("halt again", 1'b1, halted)
        `CHK("clocks", 3'h7, {osc, sclk, wosc})
        irq_pending = 1'b1;
        tick();
        irq_pending = 1'b0;
        `CHK("irq wake", 5'h0c, {halted, isvc, wc})
        tick();
        `CHK("resume", 2'h2, {cpu_run, isvc})
        $display("test irq_wake done");
        wdt_enable = 1'b1;
        go_halt();
        repeat (2) tick();
        `CHK("wdt count", 1'b1, wcnt)
        wdt_timeout = 1'b1;
        n = 0;
        while (halted === 1'b1 && n < 8) begin
            tick();
            n++;
        end
        `CHK("wdt wake", 5'h02, {halted, isvc, wc})
        // two synchroniser edges, then one edge to act
        `CHK("wdt latency", 3, n)
        wdt_timeout = 1'b0;
        repeat (4) tick();
        `CHK("wdt run", 1'b1, cpu_run)
        $display("test wdt_wake done");
        // each reset source ends halt through the reset path
        for (int i = 0; i < 3; i++) begin
            go_halt();
            reset_src = 3'h4 >> i;
            n = 0;
            while (rreq !== 1'b1 && n < 8) begin
                tick();
                n++;
            end
            `CHK("reset wake", 3'h4, {rreq, halted, isvc})
            `CHK("reset latency", 3, n)
            reset_src = '0;
            n = 0;
            while (rreq === 1'b1 && n < 16) begin
                tick();
                n++;
            end
            // pin seen low, two synchroniser edges, the hold count, one edge out
            `CHK("reset hold", `HALT_RST_HOLD_CYC + 3, n)
            repeat (2) tick();
            `CHK("reset run", 4'h9, {cpu_run, wc})
        end
        $display("test reset_wake done");
        // random disables while halted, checked against the queue model
        go_halt();
        for (int k = 0; k < 24; k++) begin
            rnd = xs();
            {dis, mode} = rnd[15:0];
            exp16 = 16'hffff;
            for (int b = 0; b < 8; b++) begin
                if (dis[b] && !mode[b]) exp16[8+b] = 1'b0;   // clock gated off
                if (dis[b] && mode[b]) exp16[b] = 1'b0;      // power removed
            end
            expq.push_back(exp16);
            tick();
            exp16 = expq.pop_front();
            `CHK("periph en", exp16, {pclk, ppwr})
        end
        `CHK("still halted", 1'b1, halted)
        irq_pending = 1'b1;
        tick();
        irq_pending = 1'b0;
        `CHK("periph wake", 2'h1, {halted, cpu_run})
        repeat (2) tick();
        $display("test periph_gate done");
        // a reset source in run resets the core and keeps the last wake cause
        reset_src = 3'h1;
        repeat (3) tick();
        `CHK("run reset", 5'h14, {rreq, cpu_run, wc})
        reset_src = '0;
        repeat (8) tick();
        `CHK("run again", 2'h2, {cpu_run, rreq})
        // counter stops once the watchdog is disabled
        wdt_enable = 1'b0;
        repeat (4) tick();
        `CHK("wdt stop", 1'b0, wcnt)
        $display("test run_reset done");
        wrap_up();
    end
endmodule
`default_nettype wire
